// [dv/rcsc_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module rcsc_sva (
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic        ext_reset_n_i,
	input wire logic        brownout_reset_enable_i,
	input wire logic        brownout_resample_enable_i,
	input wire logic        system_reset_request_i,
	input wire logic        watchdog_reset_enable_i,
	input wire logic [1:0]  oscillator_select_i,
	input wire logic        pll_skip_i,
	input wire logic        core_reset_o,
	input wire logic        tap_reset_o,
	input wire logic        boot_fetch_o,
	input wire logic        watchdog_int_o,
	input wire logic        regulator_fault_reset_flag_o,
	input wire logic [5:0]  reset_cause_register_o,
	input wire logic [1:0]  clk_source_o,
	input wire logic        clk_via_pll_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_boot_pulse;
		boot_fetch_o ##1 !boot_fetch_o;
	endsequence
	property p_pin;
		!ext_reset_n_i |=> core_reset_o && !tap_reset_o;
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset");
	property p_sys;
		system_reset_request_i |=> core_reset_o;
	endproperty
	a_sys: assert property (p_sys) else $error("system request");
	property p_boot;
		$rose(boot_fetch_o) |-> s_boot_pulse;
	endproperty
	a_boot: assert property (p_boot) else $error("boot pulse");
	property p_rel;
		$fell(core_reset_o) |-> boot_fetch_o;
	endproperty
	a_rel: assert property (p_rel) else $error("release order");
	property p_bor;
		$rose(reset_cause_register_o[2]) |->
			$past(brownout_reset_enable_i) || $past(brownout_resample_enable_i);
	endproperty
	a_bor: assert property (p_bor) else $error("brown-out gate");
	property p_wdt;
		$rose(reset_cause_register_o[3]) |-> $past(watchdog_int_o) && $past(watchdog_reset_enable_i);
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset");
	property p_ldo;
		$rose(regulator_fault_reset_flag_o) |-> ##[0:1] core_reset_o && reset_cause_register_o[5];
	endproperty
	a_ldo: assert property (p_ldo) else $error("regulator reset");
	property p_clk;
		oscillator_select_i != 2'h3 |=> clk_source_o == $past(oscillator_select_i)
			&& clk_via_pll_o != $past(pll_skip_i);
	endproperty
	a_clk: assert property (p_clk) else $error("clock select");
endmodule
bind reset_and_clock_source_control rcsc_sva u_sva (.*);
`default_nettype wire

// [dv/reset_and_clock_source_control_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module reset_and_clock_source_control_tb_top;
	logic        sys_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        ext_reset_n_i, brownout_detect_i;
	logic        regulator_unregulated_i, system_reset_request_i;
	logic        brownout_reset_enable_i = 1'b0, brownout_resample_enable_i = 1'b0;
	logic [7:0]  brownout_resample_delay_i = 8'h04;
	logic [31:0] peripheral_soft_reset_regs_i = 32'h0;
	logic        watchdog_timeout_i = 1'b0, watchdog_int_clear_i = 1'b0;
	logic        watchdog_reset_enable_i = 1'b0, regulator_reset_enable_i = 1'b0;
	logic [31:0] watchdog_reload_value_i = 32'h14;
	logic [5:0]  regulator_voltage_adjust_i = 6'h00;
	logic [1:0]  oscillator_select_i = 2'h0;
	logic        pll_skip_i = 1'b1;
	logic        core_reset_o, tap_reset_o, boot_fetch_o, brownout_int_o, watchdog_int_o;
	logic        regulator_fault_reset_flag_o, clk_via_pll_o;
	logic [31:0] periph_reset_o, watchdog_count_o;
	logic [5:0]  reset_cause_register_o, regulator_voltage_adjust_o;
	logic [1:0]  clk_source_o;
	int          errors = 0, cmp_count = 0;
	wire logic [2:0] lvl = {boot_fetch_o, core_reset_o, watchdog_int_o};

	always #50 sys_clk_i = ~sys_clk_i;

	reset_and_clock_source_control u_dut (.*);
	reset_source_model u_src (
		.sys_clk_i              (sys_clk_i),
		.ext_reset_n_o          (ext_reset_n_i),
		.brownout_detect_o      (brownout_detect_i),
		.regulator_unregulated_o(regulator_unregulated_i),
		.system_reset_request_o (system_reset_request_i)
	);

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out;
		if (errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask

	// k: 0 watchdog interrupt, 1 core reset, 2 boot fetch then release
	task automatic wait_hi(input int k);
		int i;
		for (i = 0; i < 40 && lvl[k] !== 1'b1; i++)
			cyc(1);
		if (i == 40) begin
			errors++;
			close_out();
		end
		if (k == 2) begin
			cyc(1);
			chk("release", core_reset_o, 1'b0);
		end
	endtask

	task automatic t_pin;
		u_src.drive(0, 3);
		chk("pin", {core_reset_o, tap_reset_o, &periph_reset_o, reset_cause_register_o}, 9'h141);
		wait_hi(2);
	endtask

	task automatic t_bor;
		u_src.drive(1, 3);
		chk("bor_off", {core_reset_o, brownout_int_o}, 2'h1);
		cyc(4990);
		chk("bor_int_held", brownout_int_o, 1'b1);
		cyc(20);
		chk("bor_int", brownout_int_o, 1'b0);
		brownout_resample_enable_i = 1'b1;
		u_src.drive(1, 1);
		cyc(10);
		chk("bor_noise", core_reset_o, 1'b0);
		u_src.drive(1, 10);
		chk("bor_conf", reset_cause_register_o, 6'h05);
		wait_hi(2);
		brownout_resample_enable_i = 1'b0;
		brownout_reset_enable_i = 1'b1;
		u_src.drive(1, 3);
		chk("bor_hold", core_reset_o, 1'b0);
		// wait out the hold-off so the direct reset path is reachable again
		cyc(4990);
		u_src.drive(1, 3);
		chk("bor_rst", {core_reset_o, brownout_int_o}, 2'h2);
		wait_hi(2);
		brownout_reset_enable_i = 1'b0;
	endtask

	task automatic t_soft;
		peripheral_soft_reset_regs_i = 32'h8000_0001;
		cyc(2);
		chk("soft_set", periph_reset_o, 32'h0);
		peripheral_soft_reset_regs_i = 32'h0;
		cyc(1);
		chk("soft_core", core_reset_o, 1'b0);
		chk("soft_clr", periph_reset_o, 32'h8000_0001);
		cyc(1);
		chk("soft_end", periph_reset_o, 32'h0);
	endtask

	task automatic t_sys;
		u_src.drive(3, 1);
		chk("sys", {core_reset_o, reset_cause_register_o[4]}, 2'h3);
		wait_hi(2);
	endtask

	task automatic t_wdt;
		watchdog_timeout_i = 1'b1;
		cyc(1);
		watchdog_timeout_i = 1'b0;
		wait_hi(0);
		chk("wd_load", watchdog_count_o, 32'h14);
		cyc(25);
		chk("wd_noen", core_reset_o, 1'b0);
		watchdog_int_clear_i = 1'b1;
		cyc(1);
		watchdog_int_clear_i = 1'b0;
		chk("wd_clr", watchdog_int_o, 1'b0);
		watchdog_reset_enable_i = 1'b1;
		wait_hi(0);
		wait_hi(1);
		watchdog_reset_enable_i = 1'b0;
		chk("wd_cause", reset_cause_register_o[3], 1'b1);
		wait_hi(2);
	endtask

	task automatic t_ldo;
		u_src.drive(2, 2);
		chk("ldo_off", {core_reset_o, regulator_fault_reset_flag_o}, 2'h0);
		regulator_reset_enable_i = 1'b1;
		u_src.drive(2, 2);
		chk("ldo", {core_reset_o, regulator_fault_reset_flag_o, reset_cause_register_o[5]}, 3'h7);
		wait_hi(2);
	endtask

	task automatic t_clk;
		for (int s = 0; s < 3; s++) begin
			for (int k = 0; k < 2; k++) begin
				oscillator_select_i = 2'(s);
				// through the pll when pll_skip_i is 0, direct when it is 1
				pll_skip_i = k[0];
				cyc(2);
				chk("clk", {clk_source_o, clk_via_pll_o}, {2'(s), !k[0]});
			end
		end
		oscillator_select_i = 2'h3;
		regulator_voltage_adjust_i = 6'h3F;
		cyc(2);
		chk("clk_keep", clk_source_o, 2'h2);
		chk("regulator_voltage_adjust", regulator_voltage_adjust_o, 6'h3F);
	endtask

	initial begin
		cyc(2);
		chk("por", {tap_reset_o, core_reset_o, &periph_reset_o}, 3'h7);
		rst_n_i = 1'b1;
		wait_hi(2);
		chk("por_cause", {tap_reset_o, reset_cause_register_o}, 7'h02);
		t_pin();
		t_bor();
		t_soft();
		t_sys();
		t_wdt();
		t_ldo();
		t_clk();
		close_out();
	end
endmodule
`default_nettype wire

// [dv/reset_source_model.sv]
`timescale 1ns/100ps
`default_nettype none
module reset_source_model (
	input  wire logic sys_clk_i,
	output logic      ext_reset_n_o,
	output logic      brownout_detect_o,
	output logic      regulator_unregulated_o,
	output logic      system_reset_request_o
);
	// idle: pin high on its pull-up, requesters low
	initial {ext_reset_n_o, brownout_detect_o, regulator_unregulated_o,
		system_reset_request_o} = 4'h8;
	// sel: 0 pin, 1 brown-out, 2 regulator, 3 system request; held n cycles
	task automatic drive(input int sel, input int n);
		@(negedge sys_clk_i);
		case (sel)
			0: ext_reset_n_o = 1'b0;
			1: brownout_detect_o = 1'b1;
			2: regulator_unregulated_o = 1'b1;
			default: system_reset_request_o = 1'b1;
		endcase
		repeat (n) @(negedge sys_clk_i);
		{ext_reset_n_o, brownout_detect_o, regulator_unregulated_o,
			system_reset_request_o} = 4'h8;
	endtask
endmodule
`default_nettype wire

// [hw/periph_reset_cell.sv]
`timescale 1ns/100ps
`default_nettype none
// one peripheral: reset pulse on the falling edge of its soft reset bit
module periph_reset_cell (
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	input  wire logic soft_bit_i,
	input  wire logic sys_reset_i,
	output logic      periph_reset_o
);
	logic bit_seen;
	logic next_bit_seen;
	logic next_periph_reset;

	always_comb begin
		next_bit_seen = soft_bit_i;
		// pulse covers all clock domains of the unit; system reset folds in
		next_periph_reset = sys_reset_i | (bit_seen & ~soft_bit_i);
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_seen       <= 1'b0;
			periph_reset_o <= 1'b1;
		end else begin
			bit_seen       <= next_bit_seen;
			periph_reset_o <= next_periph_reset;
		end
	end
endmodule
`default_nettype wire

// [hw/reset_and_clock_source_control.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rst_ctrl_defines.svh"

// Summary of operation
// [RL1] external pin reset clears core and peripherals, not the test port
// [RL2] after pin release, internal reset releases then core starts boot fetch
// [RL3] brown-out reset is disabled out of reset until software enables it
// [RL4] brown-out raises an interrupt or a system reset per configuration
// [RL5] brown-out resets the system directly when its reset enable is set
// [RL6] with resample on and reset enable off, recheck after delay; drop if gone
// [RL7] a confirmed brown-out asserts internal reset then releases to boot
// [RL8] brown-out condition is cleared after 500 us to avoid relatching
// [RL9] a peripheral resets when its soft reset bit is set then cleared
// [RL10] soft reset bit positions match the clock gating peripheral encoding
// [RL11] a peripheral soft reset asserts every clock domain reset of that unit
// [RL12] system reset request resets whole system including core, then boots
// [RL13] watchdog: interrupt on first time-out, reset request on second
// [RL14] after first time-out the 32-bit counter reloads and keeps counting
// [RL15] second zero with interrupt uncleared and reset enabled resets system
// [RL16] regulator fault with reset enabled sets its flag and resets system
// [RL17] regulator output adjusts in steps from 2.25 V to 2.75 V via adjust field
// [RL18] system clock from internal, main, PLL or internal divided by four
// [RL19] select 0 main, 1 internal, 2 internal/4; skip PLL 1 drives directly
// [RL20] software selects PLL only with reference 3.579545 to 8.192 MHz
// [RL21] cause bits stay across resets; a pin reset clears the other causes
// [RL22] power-on reset also resets the test access port controller
// [RL23] all requests OR into one reset, release synchronised, held some cycles
// [RL24] each source's cause bit is recorded as the internal reset asserts
module reset_and_clock_source_control (
	input  wire logic                         sys_clk_i,
	input  wire logic                         rst_n_i,
	input  wire logic                         ext_reset_n_i,
	input  wire logic                         brownout_detect_i,
	input  wire logic                         brownout_reset_enable_i,
	input  wire logic                         brownout_resample_enable_i,
	input  wire logic [`RESAMPLE_DELAY_W-1:0] brownout_resample_delay_i,
	input  wire logic [`PERIPH_W-1:0]         peripheral_soft_reset_regs_i,
	input  wire logic                         system_reset_request_i,
	input  wire logic                         watchdog_timeout_i,
	input  wire logic                         watchdog_int_clear_i,
	input  wire logic                         watchdog_reset_enable_i,
	input  wire logic [`WATCHDOG_W-1:0]       watchdog_reload_value_i,
	input  wire logic                         regulator_unregulated_i,
	input  wire logic                         regulator_reset_enable_i,
	input  wire logic [`REGULATOR_VOLTAGE_ADJUST_W-1:0]           regulator_voltage_adjust_i,
	input  wire logic [1:0]                   oscillator_select_i,
	input  wire logic                         pll_skip_i,
	output logic                              core_reset_o,
	output logic                              tap_reset_o,
	output logic [`PERIPH_W-1:0]              periph_reset_o,
	output logic                              boot_fetch_o,
	output logic                              brownout_int_o,
	output logic                              watchdog_int_o,
	output logic [`WATCHDOG_W-1:0]            watchdog_count_o,
	output logic                              regulator_fault_reset_flag_o,
	output logic [`CAUSE_W-1:0]               reset_cause_register_o,
	output logic [`REGULATOR_VOLTAGE_ADJUST_W-1:0]                regulator_voltage_adjust_o,
	output logic [1:0]                        clk_source_o,
	output logic                              clk_via_pll_o
);
	rst_ctrl_pkg::seq_state_t state;
	rst_ctrl_pkg::seq_state_t next_state;
	rst_ctrl_pkg::bor_state_t bor_state;
	rst_ctrl_pkg::bor_state_t next_bor_state;

	logic [3:0]                   hold_cnt;
	logic [3:0]                   next_hold_cnt;
	logic [15:0]                  bor_cnt;
	logic [15:0]                  next_bor_cnt;
	logic [`WATCHDOG_W-1:0]       wd_cnt;
	logic [`WATCHDOG_W-1:0]       next_wd_cnt;
	logic                         wd_int;
	logic                         next_wd_int;
	logic                         wd_reset_req;
	logic                         bor_reset_req;
	logic                         bor_int;
	logic                         next_bor_int;
	logic                         ldo_req;
	logic                         any_req;
	logic                         sys_reset;
	logic [`CAUSE_W-1:0]          cause;
	logic [`CAUSE_W-1:0]          next_cause;
	logic                         ldo_flag;
	logic                         next_ldo_flag;
	logic                         por_done;
	logic                         next_por_done;
	logic                         ext_seen;
	logic                         next_ext_seen;
	logic [`REGULATOR_VOLTAGE_ADJUST_W-1:0]           regulator_voltage_adjust;
	logic [`REGULATOR_VOLTAGE_ADJUST_W-1:0]           next_regulator_voltage_adjust;
	logic [1:0]                   clk_src;
	logic [1:0]                   next_clk_src;
	logic                         via_pll;
	logic                         next_via_pll;

	localparam logic [15:0] BOR_CLEAR = 16'(`BROWNOUT_CLEAR_CYCLES);
	localparam logic [3:0]  HOLD_LEN  = 4'(`RESET_HOLD_CYCLES);

	// watchdog: first zero raises interrupt and reloads, second zero requests reset
	always_comb begin
		next_wd_cnt  = wd_cnt;
		next_wd_int  = wd_int;
		wd_reset_req = 1'b0;
		if (watchdog_timeout_i) begin
			next_wd_cnt = watchdog_reload_value_i;
		end else if (wd_cnt == '0) begin
			next_wd_cnt = watchdog_reload_value_i; // RL14
			if (wd_int) begin
				wd_reset_req = watchdog_reset_enable_i; // RL15
			end
			next_wd_int = 1'b1; // RL13
		end else begin
			next_wd_cnt = wd_cnt - 32'h00000001;
		end
		// a time-out in the clearing cycle keeps the interrupt set
		if (watchdog_int_clear_i && !(wd_cnt == '0 && !watchdog_timeout_i)) begin
			next_wd_int = 1'b0;
		end
	end

	// brown-out: direct reset, resample check, or interrupt, then hold-off
	always_comb begin
		next_bor_state = bor_state;
		next_bor_cnt   = bor_cnt;
		next_bor_int   = bor_int;
		bor_reset_req  = 1'b0;
		case (bor_state)
			rst_ctrl_pkg::BOR_IDLE: begin
				if (brownout_detect_i) begin
					if (brownout_reset_enable_i) begin
						bor_reset_req  = 1'b1; // RL5
						next_bor_state = rst_ctrl_pkg::BOR_HOLDOFF;
						next_bor_cnt   = BOR_CLEAR;
					end else if (brownout_resample_enable_i) begin
						next_bor_state = rst_ctrl_pkg::BOR_RESAMPLE; // RL6
						next_bor_cnt   = {8'h00, brownout_resample_delay_i};
					end else begin
						next_bor_int   = 1'b1; // RL4
						next_bor_state = rst_ctrl_pkg::BOR_HOLDOFF;
						next_bor_cnt   = BOR_CLEAR;
					end
				end
			end
			rst_ctrl_pkg::BOR_RESAMPLE: begin
				if (bor_cnt != 16'h0000) begin
					next_bor_cnt = bor_cnt - 16'h0001;
				end else if (brownout_detect_i) begin
					bor_reset_req  = 1'b1; // RL7
					next_bor_state = rst_ctrl_pkg::BOR_HOLDOFF;
					next_bor_cnt   = BOR_CLEAR;
				end else begin
					next_bor_state = rst_ctrl_pkg::BOR_IDLE; // RL6
				end
			end
			rst_ctrl_pkg::BOR_HOLDOFF: begin
				// condition is dropped only after the hold-off so it cannot relatch
				if (bor_cnt != 16'h0000) begin
					next_bor_cnt = bor_cnt - 16'h0001;
				end else begin
					next_bor_state = rst_ctrl_pkg::BOR_IDLE; // RL8
					next_bor_int   = 1'b0;
				end
			end
			default: begin
				next_bor_state = rst_ctrl_pkg::BOR_IDLE;
			end
		endcase
	end

	assign ldo_req = regulator_unregulated_i & regulator_reset_enable_i; // RL16
	assign any_req = ~ext_reset_n_i | bor_reset_req | system_reset_request_i
		| wd_reset_req | ldo_req; // RL23

	// reset sequencer: hold while any request, count out, then boot fetch
	always_comb begin
		next_state    = state;
		next_hold_cnt = hold_cnt;
		next_por_done = 1'b1;
		case (state)
			rst_ctrl_pkg::SEQ_IDLE: begin
				if (any_req) begin
					next_state    = rst_ctrl_pkg::SEQ_HOLD;
					next_hold_cnt = HOLD_LEN;
				end
			end
			rst_ctrl_pkg::SEQ_HOLD: begin
				if (any_req) begin
					next_hold_cnt = HOLD_LEN; // RL23
				end else if (hold_cnt != 4'h0) begin
					next_hold_cnt = hold_cnt - 4'h1;
				end else begin
					next_state = rst_ctrl_pkg::SEQ_RELEASE; // RL2
				end
			end
			rst_ctrl_pkg::SEQ_RELEASE: begin
				next_state = any_req ? rst_ctrl_pkg::SEQ_HOLD : rst_ctrl_pkg::SEQ_IDLE;
				next_hold_cnt = HOLD_LEN;
			end
			default: begin
				next_state = rst_ctrl_pkg::SEQ_HOLD;
			end
		endcase
	end

	// cause bits are sticky; a pin reset wipes the others
	always_comb begin
		next_cause    = cause;
		next_ldo_flag = ldo_flag | ldo_req; // RL16
		next_ext_seen = ~ext_reset_n_i;
		if (!por_done) begin
			next_cause[`CAUSE_POR] = 1'b1;
		end
		if (!ext_reset_n_i && !ext_seen) begin
			next_cause = '0; // RL21
			next_cause[`CAUSE_EXT] = 1'b1; // RL24
		end
		if (bor_reset_req) begin
			next_cause[`CAUSE_BOR] = 1'b1; // RL24
		end
		if (wd_reset_req) begin
			next_cause[`CAUSE_WDT] = 1'b1;
		end
		if (system_reset_request_i) begin
			next_cause[`CAUSE_SW] = 1'b1;
		end
		if (ldo_req) begin
			next_cause[`CAUSE_LDO] = 1'b1;
		end
	end

	// clock source and regulator setting latched from software
	always_comb begin
		next_regulator_voltage_adjust    = regulator_voltage_adjust_i; // RL17
		next_via_pll = ~pll_skip_i; // RL19
		next_clk_src = clk_src;
		if (oscillator_select_i == `OSC_SEL_MAIN
			|| oscillator_select_i == `OSC_SEL_INTERNAL
			|| oscillator_select_i == `OSC_SEL_INTERNAL_DIV4) begin
			next_clk_src = oscillator_select_i; // RL18
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state     <= rst_ctrl_pkg::SEQ_HOLD; // RL22
			hold_cnt  <= 4'(`RESET_HOLD_CYCLES);
			bor_state <= rst_ctrl_pkg::BOR_IDLE; // RL3
			bor_cnt   <= 16'h0000;
			bor_int   <= 1'b0;
			wd_cnt    <= 32'hFFFFFFFF;
			wd_int    <= 1'b0;
			cause     <= `CAUSE_RESET_VAL;
			ldo_flag  <= 1'b0;
			por_done  <= 1'b0;
			ext_seen  <= 1'b0;
			regulator_voltage_adjust      <= '0;
			clk_src   <= `OSC_SEL_MAIN;
			via_pll   <= 1'b0;
		end else begin
			state     <= next_state;
			hold_cnt  <= next_hold_cnt;
			bor_state <= next_bor_state;
			bor_cnt   <= next_bor_cnt;
			bor_int   <= next_bor_int;
			wd_cnt    <= next_wd_cnt;
			wd_int    <= next_wd_int;
			cause     <= next_cause;
			ldo_flag  <= next_ldo_flag;
			por_done  <= next_por_done;
			ext_seen  <= next_ext_seen;
			regulator_voltage_adjust      <= next_regulator_voltage_adjust;
			clk_src   <= next_clk_src;
			via_pll   <= next_via_pll;
		end
	end

	// test port follows power-on only, never the pin
	assign tap_reset_o = ~por_done; // RL1
	assign sys_reset   = (state == rst_ctrl_pkg::SEQ_HOLD); // RL12
	assign core_reset_o = sys_reset; // RL1
	assign boot_fetch_o = (state == rst_ctrl_pkg::SEQ_RELEASE); // RL2

	// bit n follows the clock gating position of peripheral n
	genvar gi;
	generate
		for (gi = 0; gi < `PERIPH_W; gi++) begin : g_periph
			periph_reset_cell u_cell ( // RL9 RL10 RL11
				.sys_clk_i      (sys_clk_i),
				.rst_n_i        (rst_n_i),
				.soft_bit_i     (peripheral_soft_reset_regs_i[gi]),
				.sys_reset_i    (sys_reset),
				.periph_reset_o (periph_reset_o[gi])
			);
		end
	endgenerate

	assign brownout_int_o               = bor_int;
	assign watchdog_int_o               = wd_int;
	assign watchdog_count_o             = wd_cnt;
	assign regulator_fault_reset_flag_o = ldo_flag;
	assign reset_cause_register_o       = cause;
	assign regulator_voltage_adjust_o   = regulator_voltage_adjust;
	// PLL reference range is software's duty; hardware only routes
	assign clk_source_o                 = clk_src; // RL20
	assign clk_via_pll_o                = via_pll;
endmodule
`default_nettype wire

// [hw/rst_ctrl_defines.svh]
`ifndef RST_CTRL_DEFINES_SVH
`define RST_CTRL_DEFINES_SVH

// system clock rate and derived counts
`define SYS_CLK_HZ              10000000
`define BROWNOUT_CLEAR_US       500
`define BROWNOUT_CLEAR_CYCLES   ((`BROWNOUT_CLEAR_US * (`SYS_CLK_HZ / 1000000)))
`define RESET_HOLD_CYCLES       8
`define RESAMPLE_DELAY_W        8
`define WATCHDOG_W              32
`define PERIPH_W                32
`define REGULATOR_VOLTAGE_ADJUST_W                  6

// oscillator select encodings
`define OSC_SEL_MAIN            2'h0
`define OSC_SEL_INTERNAL        2'h1
`define OSC_SEL_INTERNAL_DIV4   2'h2

// reset cause bit positions
`define CAUSE_EXT               0
`define CAUSE_POR               1
`define CAUSE_BOR               2
`define CAUSE_WDT               3
`define CAUSE_SW                4
`define CAUSE_LDO               5
`define CAUSE_W                 6
`define CAUSE_RESET_VAL         6'h00

`endif

// [hw/rst_ctrl_pkg.sv]
package rst_ctrl_pkg;
	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'b00,
		SEQ_HOLD    = 2'b01,
		SEQ_RELEASE = 2'b10
	} seq_state_t;

	typedef enum logic [1:0] {
		BOR_IDLE     = 2'b00,
		BOR_RESAMPLE = 2'b01,
		BOR_HOLDOFF  = 2'b10
	} bor_state_t;
endpackage
